// *** hdl/pefs_pkg.sv ***
// constants, register map and carrier types for the pin function select
package pefs_pkg;

	// apb data path
	localparam int PEFS_ADDR_W = 12;
	localparam int PEFS_DATA_W = 32;
	localparam int PEFS_REG_W = 16;
	localparam int PEFS_STRB_W = 4;

	// register byte offsets
	localparam logic [11:0] PEFS_HIGH_OFS = 12'h000;
	localparam logic [11:0] PEFS_MIDDLE_OFS = 12'h004;

	// values after reset and writable bits
	localparam logic [15:0] PEFS_HIGH_RST = 16'h0000;
	localparam logic [15:0] PEFS_MIDDLE_RST = 16'h0000;
	localparam logic [15:0] PEFS_HIGH_WMASK = 16'h0FFF;
	localparam logic [15:0] PEFS_MIDDLE_WMASK = 16'hFFFF;
	localparam logic [31:0] PEFS_RDATA_RST = 32'h0000_0000;

	// pin numbering: pins 8..15 in the middle register, 16..21 in the high
	localparam int PEFS_PIN_LO = 8;
	localparam int PEFS_PIN_HI = 21;
	localparam int PEFS_PIN_N = 14;
	localparam int PEFS_HIGH_PIN_LO = 16;
	localparam int PEFS_MODE_W = 2;
	localparam int PEFS_TIMER_N = 8;

	// mode field codes
	localparam logic [1:0] PEFS_MODE_PORT = 2'h0;
	localparam logic [1:0] PEFS_MODE_ALT1 = 2'h1;
	localparam logic [1:0] PEFS_MODE_ALT2 = 2'h2;
	localparam logic [1:0] PEFS_MODE_ALT3 = 2'h3;

	// legal code sets: bit0 code 01, bit1 code 10, bit2 code 11
	localparam logic [2:0] PEFS_LEGAL_ALT1 = 3'h1;
	localparam logic [2:0] PEFS_LEGAL_ALT12 = 3'h3;
	localparam logic [2:0] PEFS_LEGAL_ALT13 = 3'h5;

	// level handed to an input that is not routed from its pin
	localparam logic PEFS_IN_IDLE = 1'b0;
	localparam logic PEFS_MANUAL_RESET_IN_IDLE = 1'b1;

	// one pin driver: level and output enable
	typedef struct packed {
		logic out;
		logic oe;
	} pefs_drive_t;

endpackage

// *** hdl/pefs_pin_sel.sv ***
// one pin: picks the driver named by its mode field
module pefs_pin_sel
	import pefs_pkg::*;
(
	// selection
	input wire logic [1:0] mode,
	input wire logic [2:0] legal,
	// candidate drivers
	input wire pefs_drive_t port_drv,
	input wire pefs_drive_t [2:0] alt_drv,
	// result
	output pefs_drive_t pin_drv,
	output logic [3:0] sel
);

	// a prohibited code falls back to the port path
	always_comb begin
		sel = 4'h1;
		pin_drv = port_drv;
		unique case (mode)
			PEFS_MODE_PORT: begin
				sel = 4'h1;
			end
			PEFS_MODE_ALT1: begin
				if (legal[0]) begin
					sel = 4'h2;
					pin_drv = alt_drv[0];
				end
			end
			PEFS_MODE_ALT2: begin
				if (legal[1]) begin
					sel = 4'h4;
					pin_drv = alt_drv[1];
				end
			end
			PEFS_MODE_ALT3: begin
				if (legal[2]) begin
					sel = 4'h8;
					pin_drv = alt_drv[2];
				end
			end
		endcase
	end

endmodule

// *** hdl/pefs_top.sv ***
// pin function select for pins 21..8: apb registers and pin multiplexer
// Operation
// - two 16-bit read/write registers hold the per-pin function fields.
// - high register bits 15:12 read zero; software writes only zero there.
// - 2-bit field per pin; pin 21 at high 11:10, pin 8 at middle 1:0.
// - pins 21..17: 00 port, 01 motor timer output; 10 and 11 prohibited.
// - pin 16: 00 port, 01 motor u phase a, 10 break trigger if offered.
// - pin 15: 00 port, 01 timer4 line d, 11 interrupt request output.
// - pin 13: 00 port, 01 timer4 line b, 10 manual reset input.
// - pin 10: 00 port, 01 timer3 line c, 10 serial2 transmit output.
// - pin 8: 00 port, 01 timer3 line a, 10 serial2 clock both ways.
// - pins 14, 12, 11, 9: 00 port, 01 timer line only.
// - in port mode the direction bit set drives the pin, clear reads it.
// - function and direction writes give the same result in either order.
//
// The implementer's own choices: the APB slave port and the register addresses.
module pefs_top
	import pefs_pkg::*;
#(
	parameter bit BREAK_TRIGGER_AVAIL = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// general port path, bit n is pin n
	input wire logic [21:8] port_dout,
	input wire logic [21:8] port_dir,
	output logic [21:8] port_din,
	// motor management timer outputs
	input wire logic motor_w_phase_b_out,
	input wire logic motor_v_phase_b_out,
	input wire logic motor_u_phase_b_out,
	input wire logic motor_w_phase_a_out,
	input wire logic motor_v_phase_a_out,
	input wire logic motor_u_phase_a_out,
	// multifunction timer lines, index 0 is timer3 line a, 7 timer4 line d
	input wire pefs_drive_t [7:0] timer_line_drv,
	output logic [7:0] timer_line_in,
	// serial, interrupt and break units
	input wire logic serial2_transmit,
	input wire pefs_drive_t serial2_clock,
	output logic serial2_clock_in,
	input wire logic interrupt_request_out,
	output logic manual_reset_in,
	input wire logic break_trigger_out,
	// pads
	input wire logic [21:8] pad_in,
	output logic [21:8] pad_out,
	output logic [21:8] pad_oe
);

	logic [15:0] high_pins_function_register_ff;
	logic [15:0] middle_pins_function_register_ff;
	logic [31:0] prdata_ff;
	logic [21:8] pad_out_ff;
	logic [21:8] pad_oe_ff;
	logic [21:8] port_din_ff;
	logic [7:0] timer_line_in_ff;
	logic serial2_clock_in_ff;
	logic manual_reset_in_ff;

	logic hit_high;
	logic hit_middle;
	logic mapped;
	logic setup_phase;
	logic access_phase;
	logic [31:0] nxt_prdata;
	logic [15:0] nxt_high;
	logic [15:0] nxt_middle;

	logic [1:0] pin_mode [21:8];
	logic [2:0] pin_legal [21:8];
	pefs_drive_t [2:0] alt_tbl [21:8];
	pefs_drive_t pin_drv [21:8];
	logic [3:0] pin_sel [21:8];

	// merges enabled byte lanes of a write under a writable-bit mask
	function automatic logic [15:0] lane_write(
		input logic [15:0] old,
		input logic [31:0] wdata,
		input logic [3:0] strb,
		input logic [15:0] wmask
	);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		lane_write = (old & ~lanes) | (wdata[15:0] & lanes);
	endfunction

	// codes a pin accepts beside port mode
	function automatic logic [2:0] legal_codes(input int pin);
		logic [2:0] codes;
		codes = PEFS_LEGAL_ALT1;
		if (pin == 16) begin
			codes = BREAK_TRIGGER_AVAIL ? PEFS_LEGAL_ALT12
				: PEFS_LEGAL_ALT1;
		end
		if (pin == 15) begin
			codes = PEFS_LEGAL_ALT13;
		end
		if (pin == 13 || pin == 10 || pin == 8) begin
			codes = PEFS_LEGAL_ALT12;
		end
		legal_codes = codes;
	endfunction

	// apb decode, zero wait states
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign hit_high = (paddr[11:2] == PEFS_HIGH_OFS[11:2]);
	assign hit_middle = (paddr[11:2] == PEFS_MIDDLE_OFS[11:2]);
	assign mapped = hit_high || hit_middle;
	assign pready = 1'b1;
	assign pslverr = access_phase && !mapped;
	assign prdata = prdata_ff;

	always_comb begin
		nxt_prdata = PEFS_RDATA_RST;
		if (hit_high) begin
			nxt_prdata[15:0] = high_pins_function_register_ff
				& PEFS_HIGH_WMASK;
		end else if (hit_middle) begin
			nxt_prdata[15:0] = middle_pins_function_register_ff;
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata_ff <= PEFS_RDATA_RST;
		end else if (setup_phase && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end

	always_comb begin
		nxt_high = lane_write(high_pins_function_register_ff, pwdata,
			pstrb, PEFS_HIGH_WMASK);
		nxt_middle = lane_write(middle_pins_function_register_ff,
			pwdata, pstrb, PEFS_MIDDLE_WMASK);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			high_pins_function_register_ff <= PEFS_HIGH_RST;
			middle_pins_function_register_ff <= PEFS_MIDDLE_RST;
		end else if (access_phase && pwrite) begin
			if (hit_high) begin
				high_pins_function_register_ff <= nxt_high;
			end
			if (hit_middle) begin
				middle_pins_function_register_ff <= nxt_middle;
			end
		end
	end

	// field extraction and candidate drivers per pin
	always_comb begin
		for (int p = PEFS_PIN_LO; p <= PEFS_PIN_HI; p++) begin
			if (p >= PEFS_HIGH_PIN_LO) begin
				pin_mode[p] = high_pins_function_register_ff[
					(p - PEFS_HIGH_PIN_LO) * 2 +: 2];
			end else begin
				pin_mode[p] = middle_pins_function_register_ff[
					(p - PEFS_PIN_LO) * 2 +: 2];
			end
			pin_legal[p] = legal_codes(p);
			alt_tbl[p] = '0;
		end
		alt_tbl[21][0] = '{out: motor_w_phase_b_out, oe: 1'b1};
		alt_tbl[20][0] = '{out: motor_v_phase_b_out, oe: 1'b1};
		alt_tbl[19][0] = '{out: motor_u_phase_b_out, oe: 1'b1};
		alt_tbl[18][0] = '{out: motor_w_phase_a_out, oe: 1'b1};
		alt_tbl[17][0] = '{out: motor_v_phase_a_out, oe: 1'b1};
		alt_tbl[16][0] = '{out: motor_u_phase_a_out, oe: 1'b1};
		alt_tbl[16][1] = '{out: break_trigger_out, oe: 1'b1};
		for (int t = 0; t < PEFS_TIMER_N; t++) begin
			alt_tbl[PEFS_PIN_LO + t][0] = timer_line_drv[t];
		end
		alt_tbl[15][2] = '{out: interrupt_request_out, oe: 1'b1};
		alt_tbl[13][1] = '{out: 1'b0, oe: 1'b0};
		alt_tbl[10][1] = '{out: serial2_transmit, oe: 1'b1};
		alt_tbl[8][1] = serial2_clock;
	end

	// the mux reads only current register state and input levels, so write order is moot
	for (genvar p = PEFS_PIN_LO; p <= PEFS_PIN_HI; p++) begin : g_pin
		pefs_pin_sel u_sel (
			.mode(pin_mode[p]),
			.legal(pin_legal[p]),
			.port_drv('{out: port_dout[p], oe: port_dir[p]}),
			.alt_drv(alt_tbl[p]),
			.pin_drv(pin_drv[p]),
			.sel(pin_sel[p])
		);
	end

	// pad drive
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pad_out_ff <= '0;
			pad_oe_ff <= '0;
		end else begin
			for (int p = PEFS_PIN_LO; p <= PEFS_PIN_HI; p++) begin
				pad_out_ff[p] <= pin_drv[p].out;
				pad_oe_ff[p] <= pin_drv[p].oe;
			end
		end
	end

	// pad levels to the units that sample them
	always_ff @(posedge core_clk) begin
		if (srst) begin
			port_din_ff <= '0;
			timer_line_in_ff <= '0;
			serial2_clock_in_ff <= PEFS_IN_IDLE;
			manual_reset_in_ff <= PEFS_MANUAL_RESET_IN_IDLE;
		end else begin
			port_din_ff <= pad_in;
			for (int t = 0; t < PEFS_TIMER_N; t++) begin
				timer_line_in_ff[t] <= pin_sel[PEFS_PIN_LO + t][1]
					? pad_in[PEFS_PIN_LO + t] : PEFS_IN_IDLE;
			end
			serial2_clock_in_ff <= pin_sel[8][2] ? pad_in[8]
				: PEFS_IN_IDLE;
			manual_reset_in_ff <= pin_sel[13][2] ? pad_in[13]
				: PEFS_MANUAL_RESET_IN_IDLE;
		end
	end

	assign pad_out = pad_out_ff;
	assign pad_oe = pad_oe_ff;
	assign port_din = port_din_ff;
	assign timer_line_in = timer_line_in_ff;
	assign serial2_clock_in = serial2_clock_in_ff;
	assign manual_reset_in = manual_reset_in_ff;

	// checks
	reserved_reads_a: assert property (
		@(posedge core_clk) disable iff (srst)
		access_phase && !pwrite && hit_high |-> prdata[31:12] == 20'h00000
	) else $error("high register reserved bits read nonzero");

	write_read_a: assert property (
		@(posedge core_clk) disable iff (srst)
		access_phase && pwrite && hit_middle && pstrb[1:0] == 2'h3
		##1 setup_phase && !pwrite && hit_middle
		|=> prdata[15:0] == $past(pwdata[15:0], 2)
	) else $error("middle register readback differs from write");

	motor_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		high_pins_function_register_ff[11:10] == PEFS_MODE_ALT1
		|=> pad_oe[21] && pad_out[21] == $past(motor_w_phase_b_out)
	) else $error("pin 21 not driven by motor w phase b");

	break_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		high_pins_function_register_ff[1:0] == PEFS_MODE_ALT2
		|=> pad_oe[16] == (BREAK_TRIGGER_AVAIL ? 1'b1
			: $past(port_dir[16]))
			&& pad_out[16] == (BREAK_TRIGGER_AVAIL
			? $past(break_trigger_out) : $past(port_dout[16]))
	) else $error("pin 16 break trigger routing wrong");

	irq_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[15:14] == PEFS_MODE_ALT3
		|=> pad_oe[15] && pad_out[15] == $past(interrupt_request_out)
	) else $error("pin 15 not driven by interrupt request");

	manual_reset_in_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[11:10] == PEFS_MODE_ALT2
		|=> !pad_oe[13] && manual_reset_in == $past(pad_in[13])
	) else $error("pin 13 manual reset input not routed");

	txd_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[5:4] == PEFS_MODE_ALT2
		|=> pad_oe[10] && pad_out[10] == $past(serial2_transmit)
	) else $error("pin 10 not driven by serial2 transmit");

	sck_route_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[1:0] == PEFS_MODE_ALT2
		|=> pad_oe[8] == $past(serial2_clock.oe)
			&& serial2_clock_in == $past(pad_in[8])
	) else $error("pin 8 serial2 clock routing wrong");

	prohibited_fallback_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[3:2] == PEFS_MODE_ALT2
		|=> pad_oe[9] == $past(port_dir[9]) && timer_line_in[1] == 1'b0
	) else $error("pin 9 prohibited code not treated as port");

	reset_clear_a: assert property (
		@(posedge core_clk)
		srst |=> high_pins_function_register_ff == PEFS_HIGH_RST
			&& middle_pins_function_register_ff == PEFS_MIDDLE_RST
			&& pad_oe == '0
	) else $error("fields not cleared by reset");

	port_dir_a: assert property (
		@(posedge core_clk) disable iff (srst)
		middle_pins_function_register_ff[9:8] == PEFS_MODE_PORT
		|=> pad_oe[12] == $past(port_dir[12])
			&& pad_out[12] == $past(port_dout[12])
	) else $error("pin 12 port mode does not follow direction");

	order_free_a: assert property (
		@(posedge core_clk) disable iff (srst)
		!$past(srst) && $stable(high_pins_function_register_ff)
		&& $stable(port_dir)
		&& $stable(port_dout) && $stable(motor_u_phase_a_out)
		&& $stable(break_trigger_out) |=> $stable(pad_oe[16])
	) else $error("pin 16 changed with no change of its inputs");

	write_high_c: cover property (
		@(posedge core_clk) disable iff (srst)
		access_phase && pwrite && hit_high
	);

	irq_pin_c: cover property (
		@(posedge core_clk) disable iff (srst)
		pin_sel[15][3]
	);

	unmapped_c: cover property (
		@(posedge core_clk) disable iff (srst)
		pslverr
	);

	b2b_read_c: cover property (
		@(posedge core_clk) disable iff (srst)
		access_phase && pwrite ##1 setup_phase && !pwrite
	);

	low_lane_c: cover property (
		@(posedge core_clk) disable iff (srst)
		access_phase && pwrite && pstrb[1:0] == 2'h1
	);

endmodule

// *** dv/pefs_periph_model.sv ***
// peripheral side model: timer, serial, interrupt and break drivers
module pefs_periph_model
	import pefs_pkg::*;
(
	// level pattern chosen by the bench
	input wire logic [23:0] pat,
	// motor timer outputs
	output logic motor_w_phase_b_out,
	output logic motor_v_phase_b_out,
	output logic motor_u_phase_b_out,
	output logic motor_w_phase_a_out,
	output logic motor_v_phase_a_out,
	output logic motor_u_phase_a_out,
	// timer lines and serial, interrupt, break units
	output pefs_drive_t [7:0] timer_line_drv,
	output logic serial2_transmit,
	output pefs_drive_t serial2_clock,
	output logic interrupt_request_out,
	output logic break_trigger_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// every source level gets its own pattern bit so a wrong route shows; the eight timer line enables share pat[21]
	assign motor_w_phase_b_out = pat[5];
	assign motor_v_phase_b_out = pat[4];
	assign motor_u_phase_b_out = pat[3];
	assign motor_w_phase_a_out = pat[2];
	assign motor_v_phase_a_out = pat[1];
	assign motor_u_phase_a_out = pat[0];
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			timer_line_drv[i].out = pat[6+i];
			timer_line_drv[i].oe = pat[21];
		end
	end
	assign serial2_transmit = pat[16];
	assign interrupt_request_out = pat[17];
	assign break_trigger_out = pat[18];
	assign serial2_clock.out = pat[19];
	assign serial2_clock.oe = pat[20];
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the pin function select block
module tb_top
	import pefs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [21:8] port_dout = 14'h1A5C;
	logic [21:8] port_dir = 14'h2C93;
	logic [21:8] pad_in = 14'h3659;
	logic [21:8] port_din, pad_out, pad_oe;
	logic [23:0] pat = 24'h5AC3A6;
	logic motor_w_phase_b_out, motor_v_phase_b_out, motor_u_phase_b_out;
	logic motor_w_phase_a_out, motor_v_phase_a_out, motor_u_phase_a_out;
	pefs_drive_t [7:0] timer_line_drv;
	pefs_drive_t serial2_clock;
	logic [7:0] timer_line_in;
	logic serial2_transmit, serial2_clock_in, interrupt_request_out;
	logic manual_reset_in, break_trigger_out;
	logic [1:0] md [21:8];
	int err_count = 0;
	int cmp_count = 0;

	always #2.5 core_clk = ~core_clk;

	pefs_periph_model u_model (.pat, .motor_w_phase_b_out,
		.motor_v_phase_b_out, .motor_u_phase_b_out, .motor_w_phase_a_out,
		.motor_v_phase_a_out, .motor_u_phase_a_out, .timer_line_drv,
		.serial2_transmit, .serial2_clock, .interrupt_request_out,
		.break_trigger_out);

	pefs_top u_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .port_dout, .port_dir,
		.port_din, .motor_w_phase_b_out, .motor_v_phase_b_out,
		.motor_u_phase_b_out, .motor_w_phase_a_out, .motor_v_phase_a_out,
		.motor_u_phase_a_out, .timer_line_drv, .timer_line_in,
		.serial2_transmit, .serial2_clock, .serial2_clock_in,
		.interrupt_request_out, .manual_reset_in, .break_trigger_out,
		.pad_in, .pad_out, .pad_oe);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// waits for pready in the access phase; a timeout counts a mismatch
	task automatic apb_wait();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk("pready", 32'h1, 32'(pready));
	endtask

	// one apb transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		apb_wait();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	// expected {out, oe} of pin p under mode m
	function automatic logic [1:0] exp_pin(int p, logic [1:0] m);
		logic [1:0] r;
		r = {port_dout[p], port_dir[p]};
		if (m == 2'h1 && p >= 16) r = {pat[p-16], 1'b1};
		else if (m == 2'h1) r = {pat[p-2], pat[21]};
		else if (m == 2'h2 && p == 16) r = {pat[18], 1'b1};
		else if (m == 2'h3 && p == 15) r = {pat[17], 1'b1};
		else if (m == 2'h2 && p == 13) r = 2'h0;
		else if (m == 2'h2 && p == 10) r = {pat[16], 1'b1};
		else if (m == 2'h2 && p == 8) r = {pat[19], pat[20]};
		return r;
	endfunction

	task automatic wr_modes();
		logic [15:0] h, m;
		logic [31:0] r;
		logic e;
		h = 16'h0000;
		m = 16'h0000;
		for (int p = 8; p < 16; p++) m[2*(p-8)+:2] = md[p];
		for (int p = 16; p < 22; p++) h[2*(p-16)+:2] = md[p];
		apb(1'b1, PEFS_HIGH_OFS, {16'h0000, h}, r, e);
		apb(1'b1, PEFS_MIDDLE_OFS, {16'h0000, m}, r, e);
	endtask

	task automatic chk_pins();
		logic [21:8] eo, ev;
		logic [7:0] ti;
		logic [1:0] d;
		for (int p = 8; p < 22; p++) begin
			d = exp_pin(p, md[p]);
			ev[p] = d[1];
			eo[p] = d[0];
		end
		for (int i = 0; i < 8; i++) ti[i] = md[i+8] == 2'h1 && pad_in[i+8];
		chk("pad_oe", 32'(eo), 32'(pad_oe));
		chk("pad_out", 32'(ev & eo), 32'(pad_out & eo));
		chk("timer_in", 32'(ti), 32'(timer_line_in));
		chk("sclk_in", 32'(md[8] == 2'h2 && pad_in[8]),
			32'(serial2_clock_in));
		chk("manual_reset_in_in", 32'(md[13] == 2'h2 ? pad_in[13] : 1'b1),
			32'(manual_reset_in));
		chk("port_din", 32'(pad_in), 32'(port_din));
	endtask

	task automatic t_regs();
		logic [31:0] r;
		logic e;
		apb(1'b0, PEFS_HIGH_OFS, 32'h0, r, e);
		chk("high_rst", 32'h0000_0000, r);
		apb(1'b1, PEFS_HIGH_OFS, 32'hFFFF_0FFF, r, e);
		apb(1'b0, PEFS_HIGH_OFS, 32'h0, r, e);
		chk("high_rw", 32'h0000_0FFF, r);
		apb(1'b1, PEFS_MIDDLE_OFS, 32'hFFFF_A5C3, r, e);
		apb(1'b0, PEFS_MIDDLE_OFS, 32'h0, r, e);
		chk("mid_rw", 32'h0000_A5C3, r);
		chk("mapped_err", 32'h0, 32'(e));
		apb(1'b1, 12'h008, 32'hFFFF_FFFF, r, e);
		chk("unmapped_err", 32'h1, 32'(e));
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("unmapped_rd", 32'h0, r);
		srst <= 1'b1;
		@(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk("rst_oe", 32'h0, 32'(pad_oe));
		chk("rst_manual_reset_in", 32'h1, 32'(manual_reset_in));
		chk("rst_prdata", 32'h0, prdata);
		apb(1'b0, PEFS_MIDDLE_OFS, 32'h0, r, e);
		chk("mid_rst", 32'h0000_0000, r);
		apb(1'b0, PEFS_HIGH_OFS, 32'h0, r, e);
		chk("high_rst2", 32'h0000_0000, r);
		$display("test registers done");
	endtask

	// write then read back with no idle cycle, then a low-lane write
	task automatic t_b2b();
		logic [31:0] r;
		logic e;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= 1'b1;
		paddr <= PEFS_MIDDLE_OFS;
		pwdata <= 32'h0000_3C96;
		pstrb <= 4'h3;
		@(posedge core_clk);
		penable <= 1'b1;
		apb_wait();
		penable <= 1'b0;
		pwrite <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		apb_wait();
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pstrb <= 4'h1;
		@(posedge core_clk);
		chk("b2b_rd", 32'h0000_3C96, r);
		apb(1'b1, PEFS_MIDDLE_OFS, 32'h0000_FFFF, r, e);
		pstrb <= 4'hF;
		apb(1'b0, PEFS_MIDDLE_OFS, 32'h0, r, e);
		chk("lane_rd", 32'h0000_3CFF, r);
		$display("test back to back done");
	endtask

	task automatic t_mux();
		for (int p = 8; p < 22; p++) begin
			for (int c = 0; c < 4; c++) begin
				foreach (md[q]) md[q] = 2'h0;
				md[p] = 2'(c);
				wr_modes();
				repeat (3) @(posedge core_clk);
				chk_pins();
				pat <= ~pat;
				port_dout <= ~port_dout;
				port_dir <= ~port_dir;
				pad_in <= ~pad_in;
				repeat (3) @(posedge core_clk);
				chk_pins();
			end
		end
		$display("test pin routing done");
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_b2b();
		t_mux();
		end_sim();
	end

	initial begin
		#50us;
		err_count++;
		end_sim();
	end
endmodule
